// ===== verilog/qspi_host_pkg.sv
// Package: constants for the quad-read and erase SPI host controller
package qspi_host_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] quad_fast_read_cmd     = 8'h6b;
    localparam logic [7:0] whole_array_erase_cmd  = 8'hc7;
    localparam logic [7:0] block_erase_cmd        = 8'hd8;
    localparam logic [7:0] sector_erase_cmd       = 8'h20;
    localparam logic [7:0] page_erase_cmd         = 8'hdb;
    localparam logic [7:0] write_enable_cmd       = 8'h06;
    localparam logic [7:0] read_status_cmd        = 8'h05;

    // ------------------------------------------------------------------
    // Frame shape
    // ------------------------------------------------------------------
    localparam logic [5:0] opcode_bits  = 6'h08;
    localparam logic [5:0] addr_bits    = 6'h18;
    localparam logic [5:0] dummy_clocks = 6'h08;
    localparam int unsigned write_in_progress_pos = 0;
    localparam int unsigned write_enable_latch_pos = 1;

    // ------------------------------------------------------------------
    // Serial clock divider: 40 MHz / (2*2) = 10 MHz
    // ------------------------------------------------------------------
    localparam logic [3:0] sck_half_period = 4'h2;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ctrl_off   = 8'h00;
    localparam logic [7:0] addr_off   = 8'h04;
    localparam logic [7:0] status_off = 8'h08;
    localparam logic [7:0] rdata_off  = 8'h0c;

    // Control fields
    localparam int unsigned ctrl_op_lsb  = 0;
    localparam int unsigned ctrl_go_pos  = 8;
    localparam int unsigned ctrl_len_lsb = 16;

    // Operation codes written to ctrl[2:0]
    localparam logic [2:0] op_read   = 3'h0;
    localparam logic [2:0] op_array  = 3'h1;
    localparam logic [2:0] op_block  = 3'h2;
    localparam logic [2:0] op_sector = 3'h3;
    localparam logic [2:0] op_page   = 3'h4;
    localparam logic [2:0] op_wren   = 3'h5;
    localparam logic [2:0] op_status = 3'h6;

    localparam logic [31:0] ctrl_reset = 32'h0000_0000;

endpackage : qspi_host_pkg

// ===== verilog/sck_divider.sv
// Serial clock tick generator: one-cycle enable at each half period
`timescale 1ns/1ps
module sck_divider
    import qspi_host_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Control
    input  wire logic run,
    output logic      tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } div_state_t;

    div_state_t state_reg;
    div_state_t state_next;

    // Count up while a frame runs; restart at idle so edges align
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.cnt = 4'h0;
        end else if (state_reg.cnt == sck_half_period - 4'h1) begin
            state_next.cnt  = 4'h0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;

endmodule : sck_divider

// ===== verilog/qspi_host.sv
// Host controller that drives the serial page EEPROM for quad read and erase
`timescale 1ns/1ps
module qspi_host
    import qspi_host_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins
    output logic             cs_n,
    output logic             sck,
    output logic             data0_out,
    output logic             data0_oe,
    input  wire logic        data0_in,
    input  wire logic        data1_in,
    input  wire logic        write_protect_data2_in,
    output logic             write_protect_data2_out,
    output logic             write_protect_data2_oe,
    input  wire logic        hold_data3_in,
    output logic             hold_data3_out,
    output logic             hold_data3_oe
);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        st_idle  = 6'b000001,
        st_cmd   = 6'b000010,
        st_addr  = 6'b000100,
        st_dummy = 6'b001000,
        st_data  = 6'b010000,
        st_end   = 6'b100000
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [2:0]  op;
        logic [23:0] addr;
        logic [15:0] len;
        logic [15:0] got;
        logic [7:0]  opcode;
        logic [5:0]  bitcnt;
        logic [31:0] rdata;
        logic [7:0]  status;
        logic        busy;
        logic        done;
        logic        rd_pend;
        logic        wr_pend;
        logic [7:0]  wr_off;
        logic [7:0]  rd_off;
        logic [31:0] hrdata;
        logic        cs_n;
        logic        sck;
        logic        d0;
        logic        d0_oe;
        logic        d23_oe;
        logic [3:0]  q_s1;
        logic [3:0]  q_s2;
        logic        nib_hi;
        logic [3:0]  nib;
    } host_state_t;

    host_state_t s_reg;
    host_state_t s_next;
    logic        tick;

    sck_divider u_div (
        .hclk   (hclk),
        .hresetn(hresetn),
        .run    (s_reg.phase != st_idle),
        .tick   (tick)
    );

    // Opcode chosen for a requested operation
    function automatic logic [7:0] op_code(input logic [2:0] op);
        case (op)
            op_read:   op_code = quad_fast_read_cmd;
            op_array:  op_code = whole_array_erase_cmd;
            op_block:  op_code = block_erase_cmd;
            op_sector: op_code = sector_erase_cmd;
            op_page:   op_code = page_erase_cmd;
            op_wren:   op_code = write_enable_cmd;
            default:   op_code = read_status_cmd;
        endcase
    endfunction : op_code

    // Whether the operation carries a 24-bit address
    function automatic logic op_has_addr(input logic [2:0] op);
        op_has_addr = (op == op_read) || (op == op_block) || (op == op_sector);
    endfunction : op_has_addr

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_next       = s_reg;
        s_next.q_s1  = {hold_data3_in, write_protect_data2_in, data1_in, data0_in};
        s_next.q_s2  = s_reg.q_s1;

        // Bus address phase capture
        s_next.rd_pend = 1'b0;
        s_next.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_next.wr_pend = hwrite;
            s_next.rd_pend = !hwrite;
            if (hwrite) begin
                s_next.wr_off = haddr[7:0];
            end else begin
                s_next.rd_off = haddr[7:0];
            end
        end

        // Read data, zero-wait
        if (s_next.rd_pend) begin
            case (s_next.rd_off)
                status_off: s_next.hrdata = {22'h0, s_reg.status, s_reg.done, s_reg.busy};
                addr_off:   s_next.hrdata = {8'h0, s_reg.addr};
                rdata_off:  s_next.hrdata = s_reg.rdata;
                ctrl_off:   s_next.hrdata = {s_reg.len, 13'h0, s_reg.op};
                default:    s_next.hrdata = 32'h0000_0000;
            endcase
        end

        // Writes: go is ignored while a frame runs
        if (s_reg.wr_pend) begin
            case (s_reg.wr_off)
                addr_off: begin
                    if (!s_reg.busy) begin
                        s_next.addr = hwdata[23:0];
                    end
                end
                ctrl_off: begin
                    if (!s_reg.busy) begin
                        s_next.op  = hwdata[ctrl_op_lsb +: 3];
                        s_next.len = hwdata[ctrl_len_lsb +: 16];
                        if (hwdata[ctrl_go_pos]) begin
                            s_next.busy   = 1'b1;
                            s_next.done   = 1'b0;
                            s_next.phase  = st_cmd;
                            s_next.opcode = op_code(hwdata[ctrl_op_lsb +: 3]);
                            s_next.bitcnt = 6'h0;
                            s_next.got    = 16'h0;
                            s_next.cs_n   = 1'b0;
                            s_next.d0_oe  = 1'b1;
                            s_next.d0     = s_next.opcode[7];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Serial engine: rising sck on a tick when low, falling when high
        if (tick) begin
            case (s_reg.phase)
                st_cmd, st_addr, st_dummy, st_data: begin
                    s_next.sck = !s_reg.sck;
                    if (!s_reg.sck) begin
                        // Rising edge: the device samples here
                        s_next.bitcnt = s_reg.bitcnt + 6'h1;
                    end else begin
                        // Falling edge: advance phase and present next bit
                        case (s_reg.phase)
                            st_cmd: begin
                                if (s_reg.bitcnt == opcode_bits) begin
                                    s_next.bitcnt = 6'h0;
                                    if (op_has_addr(s_reg.op)) begin
                                        s_next.phase = st_addr;
                                        s_next.d0    = s_reg.addr[23];
                                    end else if (s_reg.op == op_status) begin
                                        // Status byte returns on the quad pins; free data0
                                        s_next.phase  = st_data;
                                        s_next.d0_oe  = 1'b0;
                                        s_next.nib_hi = 1'b1;
                                    end else begin
                                        s_next.phase = st_end;
                                    end
                                end else begin
                                    s_next.d0 = s_reg.opcode[3'h7 - s_reg.bitcnt[2:0]];
                                end
                            end
                            st_addr: begin
                                if (s_reg.bitcnt == addr_bits) begin
                                    s_next.bitcnt = 6'h0;
                                    if (s_reg.op == op_read) begin
                                        s_next.phase  = st_dummy;
                                        s_next.d0_oe  = 1'b0;
                                    end else begin
                                        s_next.phase  = st_end;
                                    end
                                end else begin
                                    s_next.d0 = s_reg.addr[5'd23 - s_reg.bitcnt[4:0]];
                                end
                            end
                            st_dummy: begin
                                if (s_reg.bitcnt == dummy_clocks) begin
                                    s_next.bitcnt = 6'h0;
                                    s_next.phase  = st_data;
                                    s_next.nib_hi = 1'b1;
                                end
                            end
                            default: begin
                                // Data, high nibble first; taken on the falling edge
                                // because the sync flops delay the pins two cycles
                                if (s_reg.nib_hi) begin
                                    s_next.nib    = s_reg.q_s2;
                                    s_next.nib_hi = 1'b0;
                                end else begin
                                    s_next.rdata  = {s_reg.rdata[23:0], s_reg.nib,
                                                     s_reg.q_s2};
                                    s_next.nib_hi = 1'b1;
                                    s_next.got    = s_reg.got + 16'h1;
                                    if (s_reg.got + 16'h1 >= s_reg.len) begin
                                        s_next.phase = st_end;
                                    end
                                end
                            end
                        endcase
                    end
                end
                st_end: begin
                    // Raise select only after the last byte boundary
                    s_next.cs_n  = 1'b1;
                    s_next.d0_oe = 1'b0;
                    s_next.phase = st_idle;
                    s_next.busy  = 1'b0;
                    s_next.done  = 1'b1;
                    if (s_reg.op == op_status) begin
                        s_next.status = s_reg.rdata[7:0];
                    end
                end
                default: begin
                    s_next.phase = st_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg       <= '0;
            s_reg.phase <= st_idle;
            s_reg.cs_n  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state flops; bus answer and data2/data3 levels tied off
    assign hrdata                  = s_reg.hrdata;
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
    assign cs_n                    = s_reg.cs_n;
    assign sck                     = s_reg.sck;
    assign data0_out               = s_reg.d0;
    assign data0_oe                = s_reg.d0_oe;
    assign write_protect_data2_out = 1'b1;
    assign write_protect_data2_oe  = s_reg.d23_oe;
    assign hold_data3_out          = 1'b1;
    assign hold_data3_oe           = s_reg.d23_oe;

endmodule : qspi_host

// ===== testbench/qspi_host_monitor.sv
// Checker on the host controller pins
`timescale 1ns/1ps
module qspi_host_monitor
    import qspi_host_pkg::*;
(
    // Clock, reset and bus answer
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic data0_out,
    input wire logic data0_oe,
    input wire logic write_protect_data2_oe,
    input wire logic hold_data3_oe
);
    logic       sck_reg;
    logic [7:0] op_reg;
    logic [7:0] rise_reg;

    // Opcode and clock count per frame; saturates so long reads stay legal
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_reg  <= 1'b0;
            op_reg   <= 8'h00;
            rise_reg <= 8'h00;
        end else begin
            sck_reg <= sck;
            if (cs_n) begin
                rise_reg <= 8'h00;
            end else if (sck && !sck_reg && rise_reg != 8'hff) begin
                rise_reg <= rise_reg + 8'h01;
                if (rise_reg < 8'h08) begin
                    op_reg <= {op_reg[6:0], data0_out};
                end
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_sck_idle: assert property (cs_n |-> !sck)
        else $error("serial clock moves outside a frame");
    a_pins_free: assert property (!write_protect_data2_oe && !hold_data3_oe)
        else $error("host drives data2 or data3");
    a_sck_shape: assert property ($rose(sck) |=> sck ##1 !sck)
        else $error("serial clock high phase not two cycles");
    a_data_steady: assert property ($rose(sck) && data0_oe |=> $stable(data0_out))
        else $error("data0 changes while clock high");
    a_drive_framed: assert property (data0_oe |-> !cs_n)
        else $error("data0 driven outside a frame");
    a_dummy_float: assert property
        (!cs_n && op_reg == quad_fast_read_cmd && rise_reg > 8'h20 |-> !data0_oe)
        else $error("data0 driven after the address of a quad read");
    a_short_end: assert property ($rose(cs_n) && (op_reg == whole_array_erase_cmd
        || op_reg == page_erase_cmd) |-> rise_reg == 8'h08)
        else $error("opcode-only erase ends off the eighth bit");
    a_addr_end: assert property ($rose(cs_n) && (op_reg == block_erase_cmd
        || op_reg == sector_erase_cmd) |-> rise_reg == 8'h20)
        else $error("addressed erase ends off the last address bit");
    a_first_clock: assert property ($fell(cs_n) |-> ##[1:8] $rose(sck))
        else $error("no clock soon after select");

    c_read_frame: cover property ($rose(cs_n) && op_reg == quad_fast_read_cmd);
    c_page_frame: cover property ($rose(cs_n) && op_reg == page_erase_cmd);
    c_block_frame: cover property ($rose(cs_n) && op_reg == block_erase_cmd);
endmodule : qspi_host_monitor

// ===== testbench/eeprom_model.sv
// Behavioural page EEPROM: quad read, status, write enable, erase
`timescale 1ns/1ps
module eeprom_model
    import qspi_host_pkg::*;
#(
    parameter int unsigned mem_bytes = 32'h0002_0000,
    parameter int unsigned erase_ns  = 40000
)
(
    // Serial pins
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       data0,
    // Top 64-Kbyte block protected when high
    input  wire logic       prot_en,
    output logic      [3:0] dq_out,
    output logic      [3:0] dq_oe
);
    logic [7:0]  mem [mem_bytes];
    logic [31:0] sh, addr, lo, hi;
    logic [7:0]  op, b;
    logic        ok, write_in_progress_bit, write_enable_latch_bit;
    logic        protected_area_access_fail_flag, erase_fail_flag;
    int          cnt;
    event        erase_ev;

    initial begin
        for (int i = 0; i < mem_bytes; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
        {write_in_progress_bit, write_enable_latch_bit} = 2'b00;
        {protected_area_access_fail_flag, erase_fail_flag} = 2'b00;
        {dq_oe, dq_out, op, cnt} = '0;
    end
    // Frame start clears the shifter
    always @(negedge cs_n) begin
        cnt = 0;
        sh = 32'h0;
    end
    // Opcode and address taken on rising clock
    always @(posedge sck) begin
        if (!cs_n) begin
            cnt = cnt + 1;
            if (cnt <= 32) sh = {sh[30:0], data0};
            if (cnt == 8) op = sh[7:0];
            if (cnt == 32) addr = {8'h00, sh[23:0]} % mem_bytes;
        end
    end
    // Nibbles change on falling clock, high nibble first; dummies float
    always @(negedge sck) begin
        dq_oe = 4'h0;
        if (!cs_n && op == quad_fast_read_cmd && cnt >= 40 && !write_in_progress_bit) begin
            b = mem[(addr + (cnt - 40) / 2) % mem_bytes];
            dq_oe = 4'hf;
        end else if (!cs_n && op == read_status_cmd && cnt >= 8) begin
            b = {6'h00, write_enable_latch_bit, write_in_progress_bit};
            dq_oe = 4'hf;
        end
        dq_out = cnt[0] ? b[3:0] : b[7:4];
    end
    // Chip select rising ends the command; off-boundary ends are dropped
    always @(posedge cs_n) begin
        dq_oe = 4'h0;
        ok = 1'b0;
        if (!write_in_progress_bit && op == write_enable_cmd && cnt == 8) begin
            write_enable_latch_bit = 1'b1;
        end else if (!write_in_progress_bit && write_enable_latch_bit) begin
            lo = (op == whole_array_erase_cmd || cnt != 32) ? 32'h0 : addr;
            case (op)
                whole_array_erase_cmd: {ok, hi} = {cnt == 8, mem_bytes - 32'h1};
                block_erase_cmd: {ok, lo} = {cnt == 32, lo & ~32'hffff};
                sector_erase_cmd: {ok, lo} = {cnt == 32, lo & ~32'hfff};
                page_erase_cmd: {ok, lo} = {cnt > 0 && cnt % 8 == 0, lo & ~32'h1ff};
                default: ok = 1'b0;
            endcase
            if (op == block_erase_cmd) hi = lo + 32'hffff;
            if (op == sector_erase_cmd) hi = lo + 32'hfff;
            if (op == page_erase_cmd) hi = lo + 32'h1ff;
            if (ok && prot_en && hi >= mem_bytes - 32'h10000) begin
                protected_area_access_fail_flag = 1'b1;
                erase_fail_flag = 1'b1;
            end else if (ok) begin
                write_in_progress_bit = 1'b1;
                ->erase_ev;
            end
        end
    end
    // Self-timed erase; latch and busy clear together at the end
    always begin
        @(erase_ev);
        #(erase_ns);
        for (int i = lo; i <= hi; i++) mem[i] = 8'hff;
        write_enable_latch_bit = 1'b0;
        write_in_progress_bit = 1'b0;
    end
endmodule : eeprom_model

// ===== testbench/qspi_host_tb.sv
// Self-checking bench for the quad read and erase host controller
`timescale 1ns/1ps
module qspi_host_tb
    import qspi_host_pkg::*;
;
    localparam int unsigned mem_bytes = 32'h0002_0000;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cs_n, sck, junk, prot_en;
    logic        d0_out, d0_oe, wp_out, wp_oe, hd_out, hd_oe, rd_pend, noted;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, got, ea, m, e;
    logic [3:0]  dq_out, dq_oe;
    wire  [3:0]  dq;
    logic [7:0]  shadow [mem_bytes];
    logic [31:0] exp_q[$], msk_q[$];
    int          err_count, checked;

    // Released lines show a changing pattern, never a held value
    assign dq[0] = d0_oe ? d0_out : dq_oe[0] ? dq_out[0] : junk;
    assign dq[1] = dq_oe[1] ? dq_out[1] : ~junk;
    assign dq[2] = wp_oe ? wp_out : dq_oe[2] ? dq_out[2] : junk;
    assign dq[3] = hd_oe ? hd_out : dq_oe[3] ? dq_out[3] : ~junk;

    qspi_host dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n), .sck(sck),
        .data0_out(d0_out), .data0_oe(d0_oe), .data1_in(dq[1]), .write_protect_data2_in(dq[2]),
        .write_protect_data2_out(wp_out), .write_protect_data2_oe(wp_oe), .data0_in(dq[0]),
        .hold_data3_in(dq[3]), .hold_data3_out(hd_out), .hold_data3_oe(hd_oe));
    eeprom_model #(.mem_bytes(mem_bytes), .erase_ns(40000)) dev_u (.cs_n(cs_n), .sck(sck),
        .data0(dq[0]), .prot_en(prot_en), .dq_out(dq_out), .dq_oe(dq_oe));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Watchdog cuts a hang short
    initial begin
        #2250000;
        err_count++;
        results();
    end
    // Oldest note is compared when a noted read data phase completes
    always @(posedge hclk) begin
        junk <= ~junk;
        if (rd_pend && hreadyout === 1'b1 && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            e = exp_q.pop_front();
            check("hrdata", hrdata & m, e & m);
        end
        rd_pend <= hsel && htrans[1] && !hwrite && noted;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] ex);
        checked++;
        if (seen !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, ex, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        got = hrdata;
    endtask : bus
    task automatic rd_exp(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        noted = 1'b1;
        bus(1'b0, a, 32'h0);
        noted = 1'b0;
    endtask : rd_exp
    task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [15:0] len);
        bus(1'b1, addr_off, a);
        bus(1'b1, ctrl_off, {len, 7'h00, 1'b1, 5'h00, op});
        repeat (2) @(posedge hclk);
        got = 32'h1;
        for (int i = 0; i < 4000 && got[0] !== 1'b0; i++) bus(1'b0, status_off, 32'h0);
        check("busy", {31'h0, got[0]}, 32'h0);
    endtask : run_op
    task automatic rd4(input logic [31:0] a);
        run_op(op_read, a, 16'h4);
        rd_exp(rdata_off, {shadow[a % mem_bytes], shadow[(a + 1) % mem_bytes],
            shadow[(a + 2) % mem_bytes], shadow[(a + 3) % mem_bytes]}, 32'hffff_ffff);
    endtask : rd4
    task automatic st_chk(input logic [7:0] sb);
        run_op(op_status, 32'h0, 16'h1);
        rd_exp(status_off, {22'h0, sb, 2'b00}, 32'h0000_03fc);
    endtask : st_chk
    task automatic erase(input logic [2:0] op, input logic [31:0] a, input logic [31:0] lo,
                         input logic [31:0] sz);
        run_op(op_wren, 32'h0, 16'h0);
        st_chk(8'h02);
        run_op(op, a, 16'h0);
        st_chk(8'h03);
        for (int n = 0; n < 400 && (n == 0 || got[2] !== 1'b0); n++) begin
            run_op(op_status, 32'h0, 16'h1);
            bus(1'b0, status_off, 32'h0);
        end
        st_chk(8'h00);
        for (int i = 0; i < sz; i++) shadow[lo + i] = 8'hff;
        rd4(lo);
        rd4(lo + sz - 2);
    endtask : erase
    task automatic results();
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        {hresetn, hsel, htrans, haddr, hwrite, hwdata, junk, prot_en, rd_pend, noted} = '0;
        hsize = 3'b010;
        got = 32'h1;
        void'($urandom(32'h626a));
        for (int i = 0; i < mem_bytes; i++) shadow[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        check("cs_n", {31'h0, cs_n}, 32'h1);
        rd_exp(ctrl_off, ctrl_reset, 32'hffff_ffff);
        rd_exp(8'h10, 32'h0, 32'hffff_ffff);
        ea = 32'h10000 + ($urandom % 32'he000);
        rd4(ea);
        rd4(mem_bytes - 2);
        run_op(op_sector, ea, 16'h0);
        rd4(ea & ~32'hfff);
        erase(op_page, 32'h0, 32'h0, 32'h200);
        erase(op_sector, ea, ea & ~32'hfff, 32'h1000);
        erase(op_block, $urandom % 32'h10000, 32'h0, 32'h10000);
        prot_en <= 1'b1;
        run_op(op_wren, 32'h0, 16'h0);
        run_op(op_block, mem_bytes - 1, 16'h0);
        check("fail_flag", {31'h0, dev_u.erase_fail_flag}, 32'h1);
        rd4(mem_bytes - 4);
        prot_en <= 1'b0;
        erase(op_array, 32'h0, 32'h0, mem_bytes);
        results();
    end
endmodule : qspi_host_tb

bind qspi_host qspi_host_monitor mon_u (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .cs_n(cs_n), .sck(sck), .data0_out(data0_out),
    .data0_oe(data0_oe), .write_protect_data2_oe(write_protect_data2_oe),
    .hold_data3_oe(hold_data3_oe));
